// ---- verilog/adcc_top.sv ----
/*
 * control and result logic of a 10-bit a/d converter, avalon-mm slave.
 * assumes an analog front end with channel mux, sample-hold, 10-bit dac and
 * comparator outside; all front end and pin inputs are asynchronous to clk.
 */
// Local design decisions: the Avalon-MM register port and the register addresses.
//
// Contract
// - above high reference: result reads ff high and 03 low, no overflow flag; the code sets the saturation status bit.
// - below low reference: both result registers read zero.
// - output codes never decrease for a non-decreasing input.
// - four-bit channel field selects the sampled input; set before starting.
// - converter_on powers the converter and repeats conversions back to back.
// - each completion sets end-of-conversion and loads the result pair.
// - any read of the upper result register clears end-of-conversion; a completion in the same cycle keeps it set.
// - results are not latched as a pair; read both before next completion.
// - pins used as analog inputs still read as digital port inputs.
`timescale 1ns/1ps

module adcc_top (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// analog front end
	output logic [3:0] chan_sel,
	output logic conv_power,
	output logic sample_hold,
	output logic [9:0] dac_code,
	input wire logic cmp_above_in,
	input wire logic above_high_ref_in,
	input wire logic below_low_ref_in,
	// digital port pins
	input wire logic [15:0] port_pin_in,
	// interrupt
	output logic irq
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [3:0] ch;
		logic on;
		logic eoc;
		logic [7:0] res_hi;
		logic [1:0] res_lo;
		logic [1:0] irq_st;
		logic [1:0] irq_en;
		logic ack;
		logic wreq;
		logic [31:0] rdata;
		logic irq;
	} adcc_top_reg_t;

	adcc_top_reg_t st_reg;
	adcc_top_reg_t st_next;

	logic cmp_s;
	logic over_s;
	logic under_s;
	logic [15:0] port_s;
	logic sar_done;
	logic sar_sat;
	logic [9:0] sar_result;
	logic acc;
	logic rd_hi;

	// ****************************************
	// input synchronisers
	// ****************************************

	// front end comparator and reference flags
	adcc_sync #(.W(3)) u_sync_fe (
		.clk(clk),
		.rstn(rstn),
		.d({cmp_above_in, above_high_ref_in, below_low_ref_in}),
		.q({cmp_s, over_s, under_s})
	);

	// port pins, read as logic whatever the analog use
	adcc_sync #(.W(16)) u_sync_port (
		.clk(clk),
		.rstn(rstn),
		.d(port_pin_in),
		.q(port_s)
	);

	// ****************************************
	// conversion sequencer
	// ****************************************

	// runs while converter_on is set
	adcc_sar u_sar (
		.clk(clk),
		.rstn(rstn),
		.enable(st_reg.on),
		.cmp_above(cmp_s),
		.over_ref(over_s),
		.under_ref(under_s),
		.sample_hold(sample_hold),
		.dac_code(dac_code),
		.done(sar_done),
		.sat(sar_sat),
		.result(sar_result)
	);

	// ****************************************
	// bus access decode
	// ****************************************

	// one access per request, answered the cycle after it is seen
	assign acc = (avs_read || avs_write) && !st_reg.ack;
	assign rd_hi = acc && avs_read && (avs_address == adcc_pkg::OFS_RES_HIGH);

	// ****************************************
	// register file and flags
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.ack = acc;
		st_next.wreq = !acc;
		st_next.rdata = adcc_pkg::RDATA_ZERO;

		// software writes
		if (acc && avs_write) begin
			unique case (avs_address)
				adcc_pkg::OFS_CSR: begin
					st_next.ch = avs_writedata[adcc_pkg::CSR_CH_LSB +: 4];
					st_next.on = avs_writedata[adcc_pkg::CSR_ON_BIT];
				end
				adcc_pkg::OFS_IRQ_CLEAR: begin
					st_next.irq_st = st_reg.irq_st & ~avs_writedata[1:0];
				end
				adcc_pkg::OFS_IRQ_ENABLE: begin
					st_next.irq_en = avs_writedata[1:0];
				end
				default: begin
				end
			endcase
		end

		// software reads; unmapped addresses read zero
		if (acc && avs_read) begin
			unique case (avs_address)
				adcc_pkg::OFS_CSR: begin
					st_next.rdata[adcc_pkg::CSR_CH_LSB +: 4] = st_reg.ch;
					st_next.rdata[adcc_pkg::CSR_ON_BIT] = st_reg.on;
					st_next.rdata[adcc_pkg::CSR_EOC_BIT] = st_reg.eoc;
				end
				adcc_pkg::OFS_RES_HIGH: begin
					st_next.rdata[7:0] = st_reg.res_hi;
				end
				adcc_pkg::OFS_RES_LOW: begin
					st_next.rdata[1:0] = st_reg.res_lo;
				end
				adcc_pkg::OFS_PORT_IN: begin
					st_next.rdata[15:0] = port_s;
				end
				adcc_pkg::OFS_IRQ_STATUS: begin
					st_next.rdata[1:0] = st_reg.irq_st;
				end
				adcc_pkg::OFS_IRQ_ENABLE: begin
					st_next.rdata[1:0] = st_reg.irq_en;
				end
				default: begin
				end
			endcase
		end

		// high register read clears the flag
		if (rd_hi) begin
			st_next.eoc = 1'b0;
		end

		// completion loads both halves unlatched, set beats clear
		if (sar_done) begin
			st_next.eoc = 1'b1;
			st_next.res_hi = sar_result[9:2];
			st_next.res_lo = sar_result[1:0];
			st_next.irq_st[adcc_pkg::IRQ_EOC_BIT] = 1'b1;
		end
		if (sar_sat) begin
			st_next.irq_st[adcc_pkg::IRQ_SAT_BIT] = 1'b1;
		end

		// level interrupt from enabled sticky status
		st_next.irq = |(st_next.irq_st & st_next.irq_en);
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{ch: adcc_pkg::CH_RESET, irq_st: adcc_pkg::IRQ_RESET,
				irq_en: adcc_pkg::IRQ_RESET, wreq: adcc_pkg::WAITREQ_RESET, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// outputs, all from flops
	// ****************************************
	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.wreq;
	assign chan_sel = st_reg.ch;
	assign conv_power = st_reg.on;
	assign irq = st_reg.irq;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence read_high_s;
		acc && avs_read && (avs_address == adcc_pkg::OFS_RES_HIGH);
	endsequence

	sequence start_s;
		acc && avs_write && (avs_address == adcc_pkg::OFS_CSR)
			&& avs_writedata[adcc_pkg::CSR_ON_BIT] && !st_reg.on;
	endsequence

	sequence first_sample_s;
		##[1:3] sample_hold;
	endsequence

	eoc_set_a: assert property (sar_done |=> st_reg.eoc)
		else $error("completion did not set the flag");

	result_load_a: assert property (sar_done
		|=> (st_reg.res_hi == $past(sar_result[9:2]))
			&& (st_reg.res_lo == $past(sar_result[1:0])))
		else $error("result pair not loaded on completion");

	hi_clear_a: assert property (read_high_s ##0 !sar_done |=> !st_reg.eoc)
		else $error("high result read did not clear the flag");

	start_conv_a: assert property (start_s |-> first_sample_s)
		else $error("conversion did not start after switch on");

	repeat_conv_a: assert property (sar_done && st_reg.on |-> ##[1:2] sample_hold)
		else $error("conversion did not repeat");

	chan_hold_a: assert property ($changed(chan_sel)
		|-> $past(acc && avs_write && (avs_address == adcc_pkg::OFS_CSR)))
		else $error("channel changed without a write");

	port_read_a: assert property (acc && avs_read
		&& (avs_address == adcc_pkg::OFS_PORT_IN) |=> avs_readdata[15:0] == $past(port_s))
		else $error("port read does not show pin levels");

	sat_report_a: assert property (sar_done && sar_sat
		&& (sar_result == adcc_pkg::CODE_FULL)
		|=> (st_reg.res_hi == 8'hff) && (st_reg.res_lo == 2'h3))
		else $error("saturated result not reported");

	zero_report_a: assert property (sar_done
		&& (sar_result == adcc_pkg::CODE_ZERO)
		|=> (st_reg.res_hi == 8'h00) && (st_reg.res_lo == 2'h0))
		else $error("zero result not reported");

	ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer held longer than one cycle");

	irq_level_a: assert property (irq == $past(|(st_next.irq_st & st_next.irq_en)))
		else $error("interrupt does not follow enabled status");

	// ****************************************
	// register bus and flag checks
	// ****************************************

	sequence stop_s;
		acc && avs_write && (avs_address == adcc_pkg::OFS_CSR)
			&& !avs_writedata[adcc_pkg::CSR_ON_BIT];
	endsequence

	sequence read_csr_s;
		acc && avs_read && (avs_address == adcc_pkg::OFS_CSR);
	endsequence

	answer_next_a: assert property (acc |=> !avs_waitrequest)
		else $error("request not answered in the next cycle");

	rdata_idle_a: assert property (avs_waitrequest |-> (avs_readdata == adcc_pkg::RDATA_ZERO))
		else $error("read data not zero outside an answer");

	eoc_keep_a: assert property (st_reg.eoc && !rd_hi |=> st_reg.eoc)
		else $error("flag dropped without a high result read");

	eoc_cause_a: assert property ($rose(st_reg.eoc) |-> $past(sar_done))
		else $error("flag set without a completion");

	eoc_wins_a: assert property (read_high_s ##0 sar_done |=> st_reg.eoc)
		else $error("completion lost to a high result read");

	result_keep_a: assert property (!sar_done
		|=> $stable(st_reg.res_hi) && $stable(st_reg.res_lo))
		else $error("result changed without a completion");

	high_read_a: assert property (read_high_s
		|=> avs_readdata == {24'h00_0000, $past(st_reg.res_hi)})
		else $error("high result read returns wrong data");

	low_read_a: assert property (acc && avs_read
		&& (avs_address == adcc_pkg::OFS_RES_LOW)
		|=> avs_readdata == {30'h0, $past(st_reg.res_lo)})
		else $error("low result read returns wrong data");

	csr_read_a: assert property (read_csr_s
		|=> (avs_readdata[adcc_pkg::CSR_CH_LSB +: 4] == $past(st_reg.ch))
			&& (avs_readdata[adcc_pkg::CSR_ON_BIT] == $past(st_reg.on))
			&& (avs_readdata[adcc_pkg::CSR_EOC_BIT] == $past(st_reg.eoc)))
		else $error("control register read returns wrong data");

	csr_no_ovf_a: assert property (read_csr_s
		|=> (avs_readdata & 32'hffff_ff50) == adcc_pkg::RDATA_ZERO)
		else $error("control register shows an overflow flag");

	write_csr_a: assert property (acc && avs_write
		&& (avs_address == adcc_pkg::OFS_CSR)
		|=> (chan_sel == $past(avs_writedata[adcc_pkg::CSR_CH_LSB +: 4]))
			&& (conv_power == $past(avs_writedata[adcc_pkg::CSR_ON_BIT])))
		else $error("control write not applied");

	stop_conv_a: assert property (stop_s |-> ##2 !sample_hold)
		else $error("conversion kept running after switch off");

	status_read_a: assert property (acc && avs_read
		&& (avs_address == adcc_pkg::OFS_IRQ_STATUS)
		|=> avs_readdata == {30'h0, $past(st_reg.irq_st)})
		else $error("status read returns wrong data");

	done_status_a: assert property (sar_done |=> st_reg.irq_st[adcc_pkg::IRQ_EOC_BIT])
		else $error("completion did not set its status bit");

	sat_status_a: assert property (sar_sat |=> st_reg.irq_st[adcc_pkg::IRQ_SAT_BIT])
		else $error("saturation did not set its status bit");

	irq_clear_a: assert property (acc && avs_write
		&& (avs_address == adcc_pkg::OFS_IRQ_CLEAR) && !sar_done && !sar_sat
		|=> (st_reg.irq_st & $past(avs_writedata[1:0])) == 2'h0)
		else $error("status clear did not take effect");

endmodule : adcc_top

// ---- verilog/adcc_pkg.sv ----
/*
 * shared constants and types of the a/d conversion control block:
 * register offsets, field positions, reset values, timing counts, states.
 * assumes a 10 MHz system clock and a 32-bit avalon-mm register bus.
 */

package adcc_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int SAMPLE_NS = 1000;
	localparam int SETTLE_NS = 400;
	// least times round up to whole cycles
	localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// comparator reaches the sequencer through three flops and the agreement edge
	localparam int SYNC_CYC = 4;
	localparam logic [4:0] SAMPLE_LOAD = 5'(SAMPLE_CYC - 1);
	// each trial waits for the dac to settle and the comparator to cross the synchroniser
	localparam logic [4:0] SETTLE_LOAD = 5'(SETTLE_CYC + SYNC_CYC - 1);

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [4:0] OFS_CSR = 5'h00;
	localparam logic [4:0] OFS_RES_HIGH = 5'h04;
	localparam logic [4:0] OFS_RES_LOW = 5'h08;
	localparam logic [4:0] OFS_PORT_IN = 5'h0c;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
	localparam logic [4:0] OFS_IRQ_CLEAR = 5'h14;
	localparam logic [4:0] OFS_IRQ_ENABLE = 5'h18;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CSR_CH_LSB = 0;
	localparam int CSR_ON_BIT = 5;
	localparam int CSR_EOC_BIT = 7;
	localparam int IRQ_EOC_BIT = 0;
	localparam int IRQ_SAT_BIT = 1;

	// ****************************************
	// reset and fixed values
	// ****************************************
	localparam logic [3:0] CH_RESET = 4'h0;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam logic WAITREQ_RESET = 1'b1;
	localparam logic [9:0] CODE_FULL = 10'h3ff;
	localparam logic [9:0] CODE_ZERO = 10'h000;
	localparam logic [9:0] CODE_MID = 10'h200;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	// ****************************************
	// conversion sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		SAR_IDLE = 4'h1,
		SAR_SAMPLE = 4'h2,
		SAR_TRIAL = 4'h4,
		SAR_DONE = 4'h8
	} adcc_sar_state_t;

endpackage : adcc_pkg

// ---- verilog/adcc_sync.sv ----
/*
 * three-flop input synchroniser with agreement filter.
 * assumes inputs asynchronous to clk; output changes once stages 2 and 3 agree.
 */
`timescale 1ns/1ps

module adcc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} adcc_sync_state_t;

	adcc_sync_state_t st_reg;
	adcc_sync_state_t st_next;

	// shift chain; stage 1 feeds only stage 2
	always_comb begin
		st_next = st_reg;
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.q[i] = st_reg.s3[i];
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.q;

endmodule : adcc_sync

// ---- verilog/adcc_sar.sv ----
/*
 * successive approximation sequencer: sample, ten trial bits, result.
 * assumes a comparator that is high while the held input is above dac_code,
 * and reference flags, all already synchronised to clk.
 */
`timescale 1ns/1ps

module adcc_sar (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control
	input wire logic enable,
	// analog front end
	input wire logic cmp_above,
	input wire logic over_ref,
	input wire logic under_ref,
	output logic sample_hold,
	output logic [9:0] dac_code,
	// result
	output logic done,
	output logic sat,
	output logic [9:0] result
);

	typedef struct packed {
		adcc_pkg::adcc_sar_state_t fsm;
		logic [4:0] cnt;
		logic [3:0] bitn;
		logic [9:0] code;
		logic ovr;
		logic und;
		logic [9:0] result;
		logic done;
		logic sat;
		logic hold;
	} adcc_sar_reg_t;

	adcc_sar_reg_t st_reg;
	adcc_sar_reg_t st_next;

	// conversion sequence, restarted back to back while enabled
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.sat = 1'b0;
		unique case (st_reg.fsm)
			adcc_pkg::SAR_IDLE: begin
				if (enable) begin
					st_next.fsm = adcc_pkg::SAR_SAMPLE;
					st_next.cnt = adcc_pkg::SAMPLE_LOAD;
				end
			end
			adcc_pkg::SAR_SAMPLE: begin
				st_next.cnt = st_reg.cnt - 5'h01;
				if (st_reg.cnt == 5'h00) begin
					st_next.ovr = over_ref;
					st_next.und = under_ref;
					st_next.fsm = adcc_pkg::SAR_TRIAL;
					st_next.bitn = 4'h9;
					st_next.code = adcc_pkg::CODE_MID;
					st_next.cnt = adcc_pkg::SETTLE_LOAD;
				end
			end
			adcc_pkg::SAR_TRIAL: begin
				st_next.cnt = st_reg.cnt - 5'h01;
				if (st_reg.cnt == 5'h00) begin
					// binary search keeps the code monotonic in the input
					st_next.code[st_reg.bitn] = cmp_above;
					st_next.cnt = adcc_pkg::SETTLE_LOAD;
					if (st_reg.bitn == 4'h0) begin
						st_next.fsm = adcc_pkg::SAR_DONE;
					end else begin
						st_next.bitn = st_reg.bitn - 4'h1;
						st_next.code[st_reg.bitn - 4'h1] = 1'b1;
					end
				end
			end
			adcc_pkg::SAR_DONE: begin
				st_next.done = 1'b1;
				if (st_reg.ovr) begin
					st_next.result = adcc_pkg::CODE_FULL;
					st_next.sat = 1'b1;
				end else if (st_reg.und) begin
					st_next.result = adcc_pkg::CODE_ZERO;
					st_next.sat = 1'b1;
				end else begin
					st_next.result = st_reg.code;
				end
				st_next.fsm = adcc_pkg::SAR_SAMPLE;
				st_next.cnt = adcc_pkg::SAMPLE_LOAD;
			end
			default: begin
				st_next.fsm = adcc_pkg::SAR_IDLE;
			end
		endcase
		if (!enable) begin
			st_next.fsm = adcc_pkg::SAR_IDLE;
		end
		// sample strobe registered so the pin comes straight from a flop
		st_next.hold = (st_next.fsm == adcc_pkg::SAR_SAMPLE);
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{fsm: adcc_pkg::SAR_IDLE, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign sample_hold = st_reg.hold;
	assign dac_code = st_reg.code;
	assign done = st_reg.done;
	assign sat = st_reg.sat;
	assign result = st_reg.result;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	sat_high_a: assert property ((st_reg.fsm == adcc_pkg::SAR_DONE)
		&& st_reg.ovr && enable |=> done && sat && (result == adcc_pkg::CODE_FULL))
		else $error("over range result is not full scale");
	sat_low_a: assert property ((st_reg.fsm == adcc_pkg::SAR_DONE) && !st_reg.ovr
		&& st_reg.und && enable |=> done && (result == adcc_pkg::CODE_ZERO))
		else $error("under range result is not zero");
	trial_keep_a: assert property ((st_reg.fsm == adcc_pkg::SAR_TRIAL)
		&& (st_reg.cnt == 5'h00) && enable |=> dac_code[$past(st_reg.bitn)] == $past(cmp_above))
		else $error("trial bit not decided by comparator");

endmodule : adcc_sar

// ---- testbench/adcc_front_model.sv ----
/*
 * analog front end model: channel mux, reference flags and comparator.
 * assumes the bench sets the level of one live channel; the other channels
 * carry the inverse level, so a wrong channel select shows up in the result.
 */
`timescale 1ns/1ps

module adcc_front_model (
	// from the converter
	input wire logic [3:0] chan_sel,
	input wire logic conv_power,
	input wire logic [9:0] dac_code,
	// scene set by the bench
	input wire logic [3:0] live_ch,
	input wire logic [9:0] level,
	input wire logic over,
	input wire logic under,
	// to the converter
	output logic cmp_above,
	output logic above_high,
	output logic below_low
);
	logic [9:0] seen;
	logic on_live;

	// mux: only the live channel carries the scene level
	assign on_live = (chan_sel == live_ch);
	assign seen = on_live ? level : ~level;
	// level sits half a step above its code, so the comparator is monotone
	assign cmp_above = conv_power & (seen >= dac_code);
	// reference flags only on the live channel, dead while unpowered
	assign above_high = conv_power & over & on_live;
	assign below_low = conv_power & under & on_live;
endmodule : adcc_front_model

// ---- testbench/testbench.sv ----
/*
 * self-checking testbench of the a/d conversion control block.
 * assumes the front end model and the design package are compiled first.
 */
`timescale 1ns/1ps

module testbench;
	// ****************************************
	// signals
	// ****************************************
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] chan_sel;
	logic conv_power, sample_hold, irq, cmp_above, above_high, below_low;
	logic [9:0] dac_code;
	logic [15:0] port_pin_in = 16'h0000;
	logic [3:0] live_ch = 4'h0;
	logic [9:0] level = 10'h000;
	logic over = 1'b0;
	logic under = 1'b0;
	int num_errors = 0;
	int num_checks = 0;
	int seed = 67954;
	logic [31:0] rd, hi, lo;
	logic [9:0] lvl, prev;
	logic [3:0] ch;

	// clock 100 ns
	always #50 clk = ~clk;

	adcc_top u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .chan_sel(chan_sel), .conv_power(conv_power),
		.sample_hold(sample_hold), .dac_code(dac_code), .cmp_above_in(cmp_above),
		.above_high_ref_in(above_high), .below_low_ref_in(below_low),
		.port_pin_in(port_pin_in), .irq(irq));

	adcc_front_model u_front (.chan_sel(chan_sel), .conv_power(conv_power),
		.dac_code(dac_code), .live_ch(live_ch), .level(level), .over(over), .under(under),
		.cmp_above(cmp_above), .above_high(above_high), .below_low(below_low));

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			num_errors++;
			wrap_up();
		end
	endtask : bus

	// poll the end-of-conversion flag, bounded
	task automatic wait_eoc();
		int n;
		n = 0;
		do begin
			bus(1'b0, adcc_pkg::OFS_CSR, 32'h0, rd);
			n++;
		end while (rd[adcc_pkg::CSR_EOC_BIT] !== 1'b1 && n < 200);
		if (rd[adcc_pkg::CSR_EOC_BIT] !== 1'b1) begin
			num_errors++;
			wrap_up();
		end
	endtask : wait_eoc

	// set a scene, skip stale conversions, then take a full 10-bit result
	task automatic convert(input logic [9:0] l, input logic o, input logic u,
		input logic [9:0] exp);
		level <= l;
		over <= o;
		under <= u;
		bus(1'b0, adcc_pkg::OFS_RES_HIGH, 32'h0, rd);
		wait_eoc();
		bus(1'b0, adcc_pkg::OFS_RES_HIGH, 32'h0, rd);
		wait_eoc();
		bus(1'b0, adcc_pkg::OFS_RES_LOW, 32'h0, lo);
		bus(1'b0, adcc_pkg::OFS_RES_HIGH, 32'h0, hi);
		chk(hi, {24'h0, exp[9:2]});
		chk(lo, {30'h0, exp[1:0]});
		bus(1'b0, adcc_pkg::OFS_CSR, 32'h0, rd);
		chk({31'h0, rd[adcc_pkg::CSR_EOC_BIT]}, 32'h0);
	endtask : convert

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge clk);
		chk({26'h0, chan_sel, conv_power, irq}, 32'h0);
		rstn <= 1'b1;
		bus(1'b0, adcc_pkg::OFS_CSR, 32'h0, rd);
		chk(rd, 32'h0);
		bus(1'b0, adcc_pkg::OFS_IRQ_ENABLE, 32'h0, rd);
		chk(rd, 32'h0);
		// unmapped place: write ignored, read zero
		bus(1'b1, 5'h1c, 32'hffff_ffff, rd);
		bus(1'b0, 5'h1c, 32'h0, rd);
		chk(rd, 32'h0);
		// pins stay readable as logic inputs
		port_pin_in <= 16'($random(seed));
		repeat (8) @(posedge clk);
		bus(1'b0, adcc_pkg::OFS_PORT_IN, 32'h0, rd);
		chk(rd, {16'h0, port_pin_in});
		// pick a channel and switch on
		ch = 4'($random(seed));
		live_ch <= ch;
		bus(1'b1, adcc_pkg::OFS_CSR, {26'h0, 1'b1, 1'b0, ch}, rd);
		chk({27'h0, conv_power, chan_sel}, {27'h0, 1'b1, ch});
		// corner codes, then a rising random ramp
		convert(10'h000, 1'b0, 1'b0, 10'h000);
		convert(10'h3ff, 1'b0, 1'b0, 10'h3ff);
		prev = 10'h000;
		for (int i = 0; i < 6; i++) begin
			lvl = prev + 10'($random(seed) & 32'hff);
			if (lvl < prev)
				lvl = 10'h3ff;
			convert(lvl, 1'b0, 1'b0, lvl);
			chk({31'h0, ({hi[7:0], lo[1:0]} >= prev)}, 32'h1);
			prev = lvl;
		end
		// 8-bit read: high register alone clears the flag
		wait_eoc();
		bus(1'b0, adcc_pkg::OFS_RES_HIGH, 32'h0, hi);
		chk(hi, {24'h0, lvl[9:2]});
		bus(1'b0, adcc_pkg::OFS_CSR, 32'h0, rd);
		chk({31'h0, rd[adcc_pkg::CSR_EOC_BIT]}, 32'h0);
		// out of reference range saturates
		convert(10'h3ff, 1'b1, 1'b0, adcc_pkg::CODE_FULL);
		bus(1'b0, adcc_pkg::OFS_CSR, 32'h0, rd);
		chk(rd & 32'hffff_ff7f, {26'h0, 1'b1, 1'b0, ch});
		convert(10'h000, 1'b0, 1'b1, adcc_pkg::CODE_ZERO);
		// interrupt: masked, enabled, cleared
		bus(1'b0, adcc_pkg::OFS_IRQ_STATUS, 32'h0, rd);
		chk(rd, 32'h3);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, adcc_pkg::OFS_IRQ_ENABLE, 32'h1, rd);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, adcc_pkg::OFS_CSR, {28'h0, ch}, rd);
		bus(1'b1, adcc_pkg::OFS_IRQ_CLEAR, 32'h3, rd);
		bus(1'b0, adcc_pkg::OFS_IRQ_STATUS, 32'h0, rd);
		chk(rd, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wrap_up();
	end
endmodule : testbench
